// ===== verilog/vfs_pkg.sv
/*
 * Shared constants for the voltage fault status flag block: register
 * command codes, channel count and reset values.
 * Assumes the serial host front end presents decoded command codes.
 */
package vfs_pkg;

    // channels per fault class and register data width
    localparam int VFS_NUM_CH = 6;
    localparam int VFS_DATA_W = 8;
    localparam int VFS_ADDR_W = 8;
    localparam int VFS_NUM_CLASS = 3;

    // command codes of the three status registers
    localparam logic [7:0] VFS_OFF_HF_UNDERVOLT = 8'h12;
    localparam logic [7:0] VFS_OFF_LF_UNDERVOLT = 8'h14;
    localparam logic [7:0] VFS_OFF_HF_OVERVOLT = 8'h16;

    // class index, also the summary bit position
    localparam int VFS_CLS_HF_UV = 0;
    localparam int VFS_CLS_LF_UV = 1;
    localparam int VFS_CLS_HF_OV = 2;

    // reset values
    localparam logic [5:0] VFS_FLAG_RST = 6'h00;
    localparam logic [7:0] VFS_RDATA_RST = 8'h00;
    localparam logic [1:0] VFS_RSVD_BITS = 2'h0;

endpackage

// ===== verilog/vfs_flag_bank.sv
/*
 * One bank of six sticky fault flags with write-1-to-clear that only
 * takes effect in high-power mode once the fault has gone.
 * Assumes fault and enable inputs are synchronous to i_clk.
 */
`timescale 1ns/1ps
module vfs_flag_bank import vfs_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // fault conditions and enables
    input wire logic [VFS_NUM_CH-1:0] i_fault,
    input wire logic [VFS_NUM_CH-1:0] i_enable,
    input wire logic i_high_power_mode,
    // host clear request
    input wire logic i_clr_stb,
    input wire logic [VFS_NUM_CH-1:0] i_clr_mask,
    // flags
    output logic [VFS_NUM_CH-1:0] o_flags
);

    typedef struct packed {
        logic [VFS_NUM_CH-1:0] flags;
    } vfs_bank_s;

    vfs_bank_s st;
    vfs_bank_s next_st;
    logic [VFS_NUM_CH-1:0] set_vec;
    logic [VFS_NUM_CH-1:0] clr_vec;

    // set wins over clear, so a fault in the clear cycle is never lost
    always_comb begin
        next_st = st;
        set_vec = i_fault & i_enable;
        clr_vec = '0;
        // gated clear: a 0 bit or 0 data does nothing
        if (i_clr_stb && i_high_power_mode) begin
            clr_vec = i_clr_mask & ~i_fault;
        end
        next_st.flags = ((st.flags & ~clr_vec) | set_vec) & i_enable;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= '{flags: VFS_FLAG_RST};
        end else begin
            st <= next_st;
        end
    end

    assign o_flags = st.flags;

    property p_disabled_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        1 |=> (o_flags & ~$past(i_enable)) == '0;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("flag set while its enable is clear");

    property p_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_clr_stb |=> ($past(o_flags) & $past(i_enable) & ~o_flags) == '0;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a host clear");

    property p_zero_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_clr_stb |=> ($past(o_flags) & $past(i_enable)
            & ~$past(i_clr_mask) & ~o_flags) == '0;
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("writing 0 changed a flag");

endmodule

// ===== verilog/vfs_status_regs.sv
/*
 * Voltage fault status registers: three banks of six sticky flags,
 * read and write-1-to-clear by command code, plus monitor summary.
 * Assumes the host front end gives one-cycle read and write strobes
 * with an 8-bit command code, and comparator outputs are synchronous.
 */
// Functional notes
// - HF under-voltage on channel x sets bit x-1 of its status register.
// - LF under-voltage on channel x sets bit x-1 of its status register.
// - HF over-voltage on channel x sets bit x-1 of its status register.
// - status bit stays 0 while its channel enable is cleared.
// - set bit stays set after fault ends; only host write 1 or clearing its enable clears.
// - writing 0, or 1 to a clear bit, has no effect.
// - HF under-voltage clear needs high-power mode and fault gone.
// - LF under-voltage clear needs high-power mode and fault gone.
// - HF over-voltage clear needs high-power mode and fault gone.
// - summary bits 0,1,2 are OR of each status register.
`timescale 1ns/1ps
module vfs_status_regs import vfs_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // comparator outputs, high while the fault condition holds
    input wire logic [VFS_NUM_CH-1:0] i_hf_undervolt,
    input wire logic [VFS_NUM_CH-1:0] i_lf_undervolt,
    input wire logic [VFS_NUM_CH-1:0] i_hf_overvolt,
    // per-channel enables
    input wire logic [VFS_NUM_CH-1:0] i_hf_undervolt_enable,
    input wire logic [VFS_NUM_CH-1:0] i_lf_undervolt_enable,
    input wire logic [VFS_NUM_CH-1:0] i_hf_overvolt_enable,
    // power mode
    input wire logic i_high_power_mode,
    // register access from the host front end
    input wire logic [VFS_ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [VFS_DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [VFS_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // flags and summary
    output logic [VFS_NUM_CH-1:0] o_hf_undervolt_flag,
    output logic [VFS_NUM_CH-1:0] o_lf_undervolt_flag,
    output logic [VFS_NUM_CH-1:0] o_hf_overvolt_flag,
    output logic [VFS_NUM_CLASS-1:0] o_monitor_summary
);

    typedef struct packed {
        logic [VFS_DATA_W-1:0] rdata;
        logic rvalid;
    } vfs_rd_s;

    vfs_rd_s st;
    vfs_rd_s next_st;

    // one-hot class select from a command code, zero when unmapped
    function automatic logic [VFS_NUM_CLASS-1:0] vfs_class_hit(
        input logic [VFS_ADDR_W-1:0] addr
    );
        logic [VFS_NUM_CLASS-1:0] hit;
        hit = '0;
        case (addr)
            VFS_OFF_HF_UNDERVOLT: hit[VFS_CLS_HF_UV] = 1'b1;
            VFS_OFF_LF_UNDERVOLT: hit[VFS_CLS_LF_UV] = 1'b1;
            VFS_OFF_HF_OVERVOLT: hit[VFS_CLS_HF_OV] = 1'b1;
            default: hit = '0;
        endcase
        return hit;
    endfunction

    logic [VFS_NUM_CLASS-1:0][VFS_NUM_CH-1:0] fault_vec;
    logic [VFS_NUM_CLASS-1:0][VFS_NUM_CH-1:0] enable_vec;
    logic [VFS_NUM_CLASS-1:0][VFS_NUM_CH-1:0] flag_vec;
    logic [VFS_NUM_CLASS-1:0] wr_hit;
    logic [VFS_NUM_CLASS-1:0] rd_hit;

    // gather the three classes so one loop serves them all
    // per-class fault sets
    assign fault_vec = {i_hf_overvolt, i_lf_undervolt, i_hf_undervolt};
    assign enable_vec = {i_hf_overvolt_enable, i_lf_undervolt_enable,
        i_hf_undervolt_enable};
    assign wr_hit = i_reg_wr ? vfs_class_hit(i_reg_addr) : '0;
    assign rd_hit = vfs_class_hit(i_reg_addr);

    // one sticky bank per fault class; bits 7:6 of data are reserved
    genvar g;
    generate
        for (g = 0; g < VFS_NUM_CLASS; g++) begin : g_bank
            vfs_flag_bank u_bank (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_fault(fault_vec[g]),
                .i_enable(enable_vec[g]),
                .i_high_power_mode(i_high_power_mode),
                .i_clr_stb(wr_hit[g]),
                .i_clr_mask(i_reg_wdata[VFS_NUM_CH-1:0]),
                .o_flags(flag_vec[g])
            );
            assign o_monitor_summary[g] = |flag_vec[g];
        end
    endgenerate

    assign o_hf_undervolt_flag = flag_vec[VFS_CLS_HF_UV];
    assign o_lf_undervolt_flag = flag_vec[VFS_CLS_LF_UV];
    assign o_hf_overvolt_flag = flag_vec[VFS_CLS_HF_OV];

    // read path; a read in the same cycle as a clear sees the old value
    always_comb begin
        next_st = st;
        next_st.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            next_st.rdata = VFS_RDATA_RST; // unmapped codes read zero
            for (int k = 0; k < VFS_NUM_CLASS; k++) begin
                if (rd_hit[k]) begin
                    next_st.rdata = {VFS_RSVD_BITS, flag_vec[k]};
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= '{rdata: VFS_RDATA_RST, rvalid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_reg_rdata = st.rdata;
    assign o_reg_rvalid = st.rvalid;

    // helper terms watched by the checks below
    logic [VFS_NUM_CH-1:0] hf_uv_set;
    logic [VFS_NUM_CH-1:0] lf_uv_set;
    logic [VFS_NUM_CH-1:0] hf_ov_set;
    logic [VFS_NUM_CH-1:0] hf_uv_clr;
    logic [VFS_NUM_CH-1:0] lf_uv_clr;
    logic [VFS_NUM_CH-1:0] hf_ov_clr;
    logic [VFS_NUM_CH-1:0] hf_uv_hold;

    assign hf_uv_set = i_hf_undervolt & i_hf_undervolt_enable;
    assign lf_uv_set = i_lf_undervolt & i_lf_undervolt_enable;
    assign hf_ov_set = i_hf_overvolt & i_hf_overvolt_enable;
    assign hf_uv_clr = (wr_hit[VFS_CLS_HF_UV] && i_high_power_mode) ?
        (i_reg_wdata[VFS_NUM_CH-1:0] & ~i_hf_undervolt) : '0;
    assign lf_uv_clr = (wr_hit[VFS_CLS_LF_UV] && i_high_power_mode) ?
        (i_reg_wdata[VFS_NUM_CH-1:0] & ~i_lf_undervolt) : '0;
    assign hf_ov_clr = (wr_hit[VFS_CLS_HF_OV] && i_high_power_mode) ?
        (i_reg_wdata[VFS_NUM_CH-1:0] & ~i_hf_overvolt) : '0;
    assign hf_uv_hold = o_hf_undervolt_flag & i_hf_undervolt_enable;

    property p_hf_uv_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        hf_uv_set != '0 |=> (o_hf_undervolt_flag & $past(hf_uv_set))
            == $past(hf_uv_set);
    endproperty
    a_hf_uv_set: assert property (p_hf_uv_set)
        else $error("hf under-voltage fault did not set its flag");

    property p_lf_uv_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        lf_uv_set != '0 |=> (o_lf_undervolt_flag & $past(lf_uv_set))
            == $past(lf_uv_set);
    endproperty
    a_lf_uv_set: assert property (p_lf_uv_set)
        else $error("lf under-voltage fault did not set its flag");

    property p_hf_ov_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        hf_ov_set != '0 |=> (o_hf_overvolt_flag & $past(hf_ov_set))
            == $past(hf_ov_set);
    endproperty
    a_hf_ov_set: assert property (p_hf_ov_set)
        else $error("hf over-voltage fault did not set its flag");

    property p_hf_uv_clr;
        @(posedge i_clk) disable iff (!i_rst_n)
        hf_uv_clr != '0 |=> (o_hf_undervolt_flag & $past(hf_uv_clr)) == '0;
    endproperty
    a_hf_uv_clr: assert property (p_hf_uv_clr)
        else $error("hf under-voltage clear not taken");

    property p_hf_uv_lpm_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!i_high_power_mode && i_reg_wr) |=>
            (o_hf_undervolt_flag & $past(hf_uv_hold)) == $past(hf_uv_hold);
    endproperty
    a_hf_uv_lpm_hold: assert property (p_hf_uv_lpm_hold)
        else $error("hf under-voltage cleared outside high-power mode");

    property p_lf_uv_clr;
        @(posedge i_clk) disable iff (!i_rst_n)
        lf_uv_clr != '0 |=> (o_lf_undervolt_flag & $past(lf_uv_clr)) == '0;
    endproperty
    a_lf_uv_clr: assert property (p_lf_uv_clr)
        else $error("lf under-voltage clear not taken");

    property p_hf_ov_clr;
        @(posedge i_clk) disable iff (!i_rst_n)
        hf_ov_clr != '0 |=> (o_hf_overvolt_flag & $past(hf_ov_clr)) == '0;
    endproperty
    a_hf_ov_clr: assert property (p_hf_ov_clr)
        else $error("hf over-voltage clear not taken");

    property p_summary;
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_hf_overvolt_flag != '0) |-> o_monitor_summary[2] ##1
            (o_monitor_summary[2] == (o_hf_overvolt_flag != '0));
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary bit does not follow its status register");

    property p_reset_clear;
        @(posedge i_clk)
        !i_rst_n |=> (flag_vec == '0) && !o_reg_rvalid;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("status not cleared by reset");

    property p_read_data;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_rd && i_reg_addr == VFS_OFF_LF_UNDERVOLT) |=> o_reg_rvalid
            && o_reg_rdata == {VFS_RSVD_BITS, $past(o_lf_undervolt_flag)};
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data does not show the status register");

endmodule

// ===== tb/vfs_host_model.sv
/*
 * Host-side stand-in: drives one register access per cycle toward the
 * fault status registers, as the serial front end would decode it.
 * Assumes the caller invokes issue just after a falling clock edge.
 */
`timescale 1ns/1ps
module vfs_host_model import vfs_pkg::*; (
    // register access toward the device
    output logic [VFS_ADDR_W-1:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [VFS_DATA_W-1:0] o_reg_wdata,
    output logic o_reg_rd
);
    // idle bus at time zero
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd = 1'b0;
    end

    // with no strobe the code and data lines flip, so stale values
    // cannot pass for a held request
    task automatic issue(input logic r, input logic w,
                         input logic [7:0] a, input logic [7:0] d);
        o_reg_rd = r;
        o_reg_wr = w;
        o_reg_addr = (r | w) ? a : ~o_reg_addr;
        o_reg_wdata = w ? d : ~o_reg_wdata;
    endtask
endmodule

// ===== tb/test_vfs_status_regs.sv
/*
 * Self-checking bench for the voltage fault status registers: directed
 * set and clear corners per class, then seeded random traffic.
 * Assumes the host model drives the register strobes of the dut.
 */
`timescale 1ns/1ps
module test_vfs_status_regs import vfs_pkg::*; ();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] flt [3] = '{6'h00, 6'h00, 6'h00};
    logic [5:0] en [3] = '{6'h00, 6'h00, 6'h00};
    logic high_power_mode = 1'b0;
    logic [5:0] nf [3];
    logic [5:0] ne [3];
    logic nh;
    logic [5:0] ex [3];
    logic [5:0] fo [3];
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic [2:0] summ;
    logic [7:0] offs [3] = '{8'h12, 8'h14, 8'h16};
    integer seed = 30562;
    integer err_total = 0;
    integer checked = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    vfs_host_model host (.o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_wdata(wdata), .o_reg_rd(rd));

    vfs_status_regs dut (.i_clk(clk), .i_rst_n(rst_n),
        .i_hf_undervolt(flt[0]), .i_lf_undervolt(flt[1]),
        .i_hf_overvolt(flt[2]), .i_hf_undervolt_enable(en[0]),
        .i_lf_undervolt_enable(en[1]), .i_hf_overvolt_enable(en[2]),
        .i_high_power_mode(high_power_mode), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_hf_undervolt_flag(fo[0]),
        .o_lf_undervolt_flag(fo[1]), .o_hf_overvolt_flag(fo[2]),
        .o_monitor_summary(summ));

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // sticky flag: set wins, clear needs hpm and fault gone, enable gates
    function automatic logic [5:0] nxt(input logic [5:0] f,
        input logic [5:0] c, input logic [5:0] e, input logic hit,
        input logic [7:0] d, input logic h);
        logic [5:0] clr;
        clr = (hit & h) ? d[5:0] & ~c : 6'h00;
        return ((f & ~clr) | c) & e;
    endfunction

    // one cycle: drive staged inputs and an access, then compare
    task automatic step(input logic r, input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        logic [5:0] nx [3];
        logic [7:0] rexp;
        rexp = 8'h00;
        @(negedge clk);
        flt = nf;
        en = ne;
        high_power_mode = nh;
        host.issue(r, w, a, d);
        for (int k = 0; k < 3; k++) begin
            nx[k] = nxt(ex[k], nf[k], ne[k], w && a == offs[k], d, nh);
            if (a == offs[k]) begin
                rexp = {2'b00, ex[k]};
            end
        end
        @(posedge clk);
        #1;
        chk("hf_uv_flag", 8'(fo[0]), 8'(nx[0]));
        chk("lf_uv_flag", 8'(fo[1]), 8'(nx[1]));
        chk("hf_ov_flag", 8'(fo[2]), 8'(nx[2]));
        ex = nx;
        chk("summary", {5'h00, summ}, {5'h00, |ex[2], |ex[1], |ex[0]});
        chk("rvalid", {7'h00, rvalid}, {7'h00, r});
        if (r) begin
            chk("rdata", rdata, rexp);
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        // drop stale strobes and faults so no old access replays on release
        host.issue(1'b0, 1'b0, 8'h00, 8'h00);
        flt = '{6'h00, 6'h00, 6'h00};
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        ex = '{6'h00, 6'h00, 6'h00};
        for (int k = 0; k < 3; k++) begin
            chk("reset", {2'b00, fo[k]}, 8'h00);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] m;
        nf = '{6'h00, 6'h00, 6'h00};
        ne = '{6'h3F, 6'h3F, 6'h3F};
        nh = 1'b1;
        do_reset();
        // directed corners on channel 1 and channel 6 of each class
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 6; c += 5) begin
                m = 8'h01 << c;
                nf[k] = m[5:0];
                step(1'b0, 1'b0, offs[k], 8'h00);
                nf[k] = 6'h00;
                step(1'b1, 1'b1, offs[k], 8'h00);
                nh = 1'b0;
                step(1'b0, 1'b1, offs[k], m);
                nh = 1'b1;
                nf[k] = m[5:0];
                step(1'b0, 1'b1, offs[k], 8'hFF);
                nf[k] = 6'h00;
                step(1'b1, 1'b1, offs[k], m);
                step(1'b1, 1'b1, offs[k], m);
                nf[k] = m[5:0];
                ne[k] = ~m[5:0];
                step(1'b1, 1'b0, offs[k], 8'h00);
                ne[k] = 6'h3F;
                // a set flag drops once its enable is cleared
                step(1'b0, 1'b0, offs[k], 8'h00);
                nf[k] = 6'h00;
                ne[k] = ~m[5:0];
                step(1'b1, 1'b0, offs[k], 8'h00);
                ne[k] = 6'h3F;
            end
        end
        // seeded random traffic with a reset in mid-run
        for (int i = 0; i < 3000; i++) begin
            for (int k = 0; k < 3; k++) begin
                nf[k] = 6'($random(seed) & $random(seed));
                ne[k] = 6'($random(seed) | $random(seed));
            end
            nh = 1'($random(seed));
            m = offs[$unsigned($random(seed)) % 3];
            if (($random(seed) & 3) == 3) begin
                m = 8'h11; // unmapped code
            end
            step(1'($random(seed)), 1'($random(seed)), m, 8'($random(seed)));
            if (i == 1500) begin
                do_reset();
            end
        end
        tally_and_finish();
    end
endmodule
